// ==== fault_log_pkg.sv ====
// Purpose: Shared constants and types for the fault response and logging block
// Assumes: 40 MHz core clock; command layer of the serial port sits outside
// Notes: Command codes match the serial command set of the supply manager
package fault_log_pkg;
  localparam int CLK_NS = 25;
  localparam int RETRY_TICK_NS = 1000000;
  localparam int RETRY_TICK_CYCLES = (RETRY_TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int NV_WRITE_NS = 2000000;
  localparam int NV_WRITE_CYCLES = (NV_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] CMD_FAULT_RETRY = 8'h00DA;
  localparam logic [7:0] CMD_FAULT_LOG = 8'h00DC;
  localparam logic [15:0] RETRY_DELAY_RST = 16'h0000;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_LATCH = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [1:0] RESP_LOG_ONLY = 2'h3;
  localparam int BIT_GLOBAL = 14;
  localparam int BIT_NONVOLATILE_LOG_ENABLE = 15;
  localparam int BIT_ASSERT_EN = 16;
  localparam int BIT_ALARM = 8;
  localparam int KIND_OV = 0;
  localparam int KIND_UV = 1;
  localparam int KIND_SEQ = 2;
  localparam int KIND_OT = 3;
  localparam logic [5:0] SEL_SEQUENCE = 6'h10;
  localparam logic [5:0] SEL_VMON = 6'h20;
  localparam logic [2:0] ALARM_SEQ = 3'h1;
  localparam int NUM_LOGS = 15;
  localparam logic [7:0] LOG_LAST_BYTE = 8'h00FE;
  localparam logic [7:0] LOG_VALID_MARK = 8'h00DD;
  localparam logic [7:0] BLANK_BYTE = 8'h00FF;
  localparam logic [7:0] BYTE_COUNT_LO = 8'h0002;
  localparam logic [7:0] BYTE_CHAN = 8'h0004;
  localparam logic [7:0] BYTE_KIND = 8'h0005;
  localparam logic [7:0] BYTE_READINGS = 8'h0006;
  typedef enum logic [2:0] {LW_IDLE = 3'b001, LW_WRITE = 3'b010, LW_CLEAR = 3'b100} lw_state_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_STREAM = 2'b10} rd_state_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic block;
    logic [7:0] code;
    logic [15:0] data;
  } cmd_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } resp_t;
endpackage

// ==== fault_response_logger.sv ====
// Purpose: Fault responses, retry timing, alarms, alert and nonvolatile fault logs
// Assumes: All inputs synchronous to core_clk; fault_hit are one-cycle pulses
// Notes: Log storage is flip-flops standing in for the nonvolatile array
// Overview of operation
// - Code 11 sets status, logs if enabled, no output action.
// - Code 00 sets status only; no log, no output change.
// - Global retry asserts enabled fault outputs, releases after delay if fault-free.
// - Global latch asserts enabled fault outputs and holds them.
// - Local retry turns supply off, restarts after delay if fault-free.
// - Local latch turns supply off and keeps it off until master power-off.
// - Responding fault latches status; new status raises alert if enabled.
// - Undervoltage or overvoltage alarm follows its condition only.
// - Sequencing alarm latches until clear faults or master power-off.
// - One retry delay for all; timer starts at the fault.
// - Undervoltage on sequenced channel releases unconditionally at expiry.
// - Otherwise release at expiry only if no fault present.
// - Fifteen logs of 255 bytes each.
// - Read 32 returns the log in four-byte packets.
// - Block read returns 255 bytes with no byte count.
// - Unwritten log reads FFh except bytes 0 and 1.
// - Logging fault copies current readings, channel and fault kind into a log.
// - After fifteen writes set status bit, then stop or overwrite oldest.
// - Log clear bit erases stored logs.
// - Unmeasured positions read 0000h.
// - Config bit 14 selects local or global scope.
// - Config bits 18 to 16 enable each fault output.
// - Config bit 15 enables nonvolatile logging.
`timescale 1ns/1ps
`default_nettype none
module fault_response_logger #(
  parameter int NUM_CH = 16,
  parameter int TICK_CYCLES = fault_log_pkg::RETRY_TICK_CYCLES,
  parameter int WRITE_CYCLES = fault_log_pkg::NV_WRITE_CYCLES
) (
  input wire logic core_clk, // 40 MHz clock
  input wire logic reset, // Synchronous, active high
  input wire logic [NUM_CH-1:0][31:0] fault_response_config, // Per-channel response setup
  input wire logic [NUM_CH-1:0][5:0] channel_config, // Per-channel selection code
  input wire logic [NUM_CH-1:0][3:0] fault_hit, // Fault declared, per kind, pulse
  input wire logic [NUM_CH-1:0] uv_level, // Undervoltage fault present
  input wire logic [NUM_CH-1:0] ov_level, // Overvoltage/overcurrent fault present
  input wire logic [NUM_CH-1:0] uv_warn, // Undervoltage warning present
  input wire logic [NUM_CH-1:0] ov_warn, // Overvoltage/overcurrent warning present
  input wire logic [NUM_CH-1:0] other_fault, // Any non-undervoltage fault present
  input wire logic [NUM_CH-1:0] supply_request, // Sequencer wants supply on
  input wire logic [NUM_CH-1:0] measure_enable, // Channel measured
  input wire logic [NUM_CH-1:0][15:0] reading, // Working readings
  input wire logic alert_enable, // Alert allowed
  input wire logic clear_faults, // Clear faults command, pulse
  input wire logic operation_off, // Master off by command, pulse
  input wire logic [3:0] power_control_input_n, // Master off pins, low = off
  input wire logic log_overwrite_select, // 1 = overwrite oldest log
  input wire logic log_clear_bit, // Erase logs, pulse
  input wire fault_log_pkg::cmd_t cmd, // Command from serial layer
  output var fault_log_pkg::resp_t resp, // Read answer
  output logic [2:0] fault_output_n, // Shared fault outputs, low active
  output logic [NUM_CH-1:0] supply_enable_n, // Supply enables, low active
  output logic [NUM_CH-1:0] general_output_n, // Alarm outputs, low active
  output logic [NUM_CH-1:0][3:0] fault_status, // Latched status per kind
  output logic status_cml_bit0, // All fifteen logs used
  output logic alert_n, // Alert line, low active
  output logic log_busy // Log write or clear in progress
);
  localparam int NL = fault_log_pkg::NUM_LOGS;

  function automatic logic [1:0] resp_code(input logic [31:0] cfg, input int k);
    resp_code = cfg[k*2 +: 2];
  endfunction

  function automatic logic [3:0] next_slot(input logic [3:0] s);
    next_slot = (s == 4'(NL - 1)) ? 4'h0 : 4'(s + 4'h1);
  endfunction

  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [15:0] retry_delay_q;
  logic [NUM_CH-1:0][15:0] retry_cnt_q;
  logic [NUM_CH-1:0] retry_on_q, uv_trig_q, psoff_q;
  logic [NUM_CH-1:0][2:0] fmask_q;
  logic [NUM_CH-1:0][3:0] status_q;
  logic [NUM_CH-1:0] seq_alarm_q, galarm_n_q, psen_n_q;
  logic [2:0] fout_n_q;
  logic alert_n_q, cml_q;
  logic master_off;
  logic [NUM_CH-1:0] log_req;
  logic [NUM_CH-1:0][1:0] log_kind_req;

  // Retry time base
  always_ff @(posedge core_clk) begin
    if (reset || tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
    tick_q <= !reset && tick_cnt_q == 32'(TICK_CYCLES - 1);
  end

  assign master_off = operation_off || (power_control_input_n != 4'hF);

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      log_req[c] = 1'b0;
      log_kind_req[c] = 2'h0;
      for (int k = 0; k < 4; k++) begin
        if (fault_hit[c][k] && resp_code(fault_response_config[c], k) != fault_log_pkg::RESP_IGNORE
            && fault_response_config[c][fault_log_pkg::BIT_NONVOLATILE_LOG_ENABLE]) begin
          log_req[c] = 1'b1;
          log_kind_req[c] = 2'(k);
        end
      end
    end
  end

  // Per-channel responses and retry timers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      retry_cnt_q <= '0;
      retry_on_q <= '0;
      uv_trig_q <= '0;
      psoff_q <= '0;
      fmask_q <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (retry_on_q[c] && tick_q) begin
          if (retry_cnt_q[c] >= retry_delay_q) begin
            if ((uv_trig_q[c] && channel_config[c] == fault_log_pkg::SEL_SEQUENCE) || !other_fault[c]) begin
              fmask_q[c] <= 3'h0;
              psoff_q[c] <= 1'b0;
              retry_on_q[c] <= 1'b0;
            end else begin
              retry_cnt_q[c] <= 16'h0000;
            end
          end else begin
            retry_cnt_q[c] <= retry_cnt_q[c] + 16'h0001;
          end
        end
        if (master_off && !retry_on_q[c]) begin
          psoff_q[c] <= 1'b0;
        end
        for (int k = 0; k < 4; k++) begin
          if (fault_hit[c][k] && resp_code(fault_response_config[c], k) inside
              {fault_log_pkg::RESP_RETRY, fault_log_pkg::RESP_LATCH}) begin
            if (fault_response_config[c][fault_log_pkg::BIT_GLOBAL]) begin
              fmask_q[c] <= fmask_q[c] | fault_response_config[c][fault_log_pkg::BIT_ASSERT_EN +: 3];
            end else begin
              psoff_q[c] <= 1'b1;
            end
            retry_on_q[c] <= resp_code(fault_response_config[c], k) == fault_log_pkg::RESP_RETRY;
            retry_cnt_q[c] <= 16'h0000;
            uv_trig_q[c] <= k == fault_log_pkg::KIND_UV;
          end
        end
      end
    end
  end

  // Outputs, status, alarms and alert
  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_q <= '0;
      seq_alarm_q <= '0;
      galarm_n_q <= '1;
      psen_n_q <= '1;
      fout_n_q <= 3'h7;
      alert_n_q <= 1'b1;
    end else begin
      logic [2:0] any_mask;
      logic new_bit;
      any_mask = 3'h0;
      new_bit = 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
        logic [2:0] ac;
        logic uvc, ovc;
        ac = fault_response_config[c][fault_log_pkg::BIT_ALARM +: 3];
        any_mask = any_mask | fmask_q[c];
        psen_n_q[c] <= !(supply_request[c] && !psoff_q[c]);
        new_bit = new_bit || |(fault_hit[c] & ~status_q[c]);
        status_q[c] <= (clear_faults ? 4'h0 : status_q[c]) | fault_hit[c];
        if (fault_hit[c][fault_log_pkg::KIND_SEQ]) begin
          seq_alarm_q[c] <= 1'b1;
        end else if (clear_faults || master_off) begin
          seq_alarm_q[c] <= 1'b0;
        end
        uvc = ac[1] && (uv_level[c] || (ac[0] && uv_warn[c]));
        ovc = ac[2] && (ov_level[c] || (ac[0] && ov_warn[c]));
        galarm_n_q[c] <= !((ac == fault_log_pkg::ALARM_SEQ && seq_alarm_q[c]) || uvc || ovc);
      end
      fout_n_q <= ~any_mask;
      if (new_bit && alert_enable) begin
        alert_n_q <= 1'b0;
      end else if (clear_faults) begin
        alert_n_q <= 1'b1;
      end
    end
  end

  // Log storage and writer
  fault_log_pkg::lw_state_t lw_state_q;
  logic [NUM_CH-1:0] pend_q;
  logic [NUM_CH-1:0][1:0] pend_kind_q;
  logic [NL-1:0] valid_q;
  logic [NL-1:0][15:0] count_q;
  logic [NL-1:0][7:0] chan_q;
  logic [NL-1:0][7:0] kind_q;
  logic [NL-1:0][NUM_CH-1:0][15:0] rd_mem_q;
  logic [3:0] wr_ptr_q, lw_slot_q;
  logic [4:0] written_q;
  logic [15:0] log_counter_q;
  logic [31:0] lw_cnt_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lw_state_q <= fault_log_pkg::LW_IDLE;
      pend_q <= '0;
      pend_kind_q <= '0;
      valid_q <= '0;
      wr_ptr_q <= 4'h0;
      lw_slot_q <= 4'h0;
      written_q <= 5'h00;
      log_counter_q <= 16'h0000;
      lw_cnt_q <= 32'h0000_0000;
      cml_q <= 1'b0;
    end else begin
      logic [NUM_CH-1:0] pend_n;
      int pick;
      pend_n = pend_q;
      pick = -1;
      for (int c = NUM_CH - 1; c >= 0; c--) begin
        if (pend_q[c]) begin
          pick = c;
        end
      end
      if (clear_faults) begin
        cml_q <= 1'b0;
      end
      case (lw_state_q)
        fault_log_pkg::LW_IDLE: begin
          lw_cnt_q <= 32'h0000_0000;
          if (log_clear_bit) begin
            lw_state_q <= fault_log_pkg::LW_CLEAR;
          end else if (pick >= 0) begin
            pend_n[pick] = 1'b0;
            if (written_q < 5'(NL) || log_overwrite_select) begin
              lw_state_q <= fault_log_pkg::LW_WRITE;
              lw_slot_q <= wr_ptr_q;
              chan_q[wr_ptr_q] <= 8'(pick);
              kind_q[wr_ptr_q] <= {6'h00, pend_kind_q[pick]};
              count_q[wr_ptr_q] <= log_counter_q;
              valid_q[wr_ptr_q] <= 1'b0;
              for (int c = 0; c < NUM_CH; c++) begin
                rd_mem_q[wr_ptr_q][c] <= measure_enable[c] ? reading[c] : 16'h0000;
              end
            end
          end
        end
        fault_log_pkg::LW_WRITE: begin
          lw_cnt_q <= lw_cnt_q + 32'h0000_0001;
          if (lw_cnt_q == 32'(WRITE_CYCLES - 1)) begin
            lw_state_q <= fault_log_pkg::LW_IDLE;
            valid_q[lw_slot_q] <= 1'b1;
            wr_ptr_q <= next_slot(wr_ptr_q);
            log_counter_q <= log_counter_q + 16'h0001;
            if (written_q < 5'(NL)) begin
              written_q <= written_q + 5'h01;
            end
            if (written_q == 5'(NL - 1)) begin
              cml_q <= 1'b1;
            end
          end
        end
        fault_log_pkg::LW_CLEAR: begin
          lw_cnt_q <= lw_cnt_q + 32'h0000_0001;
          if (lw_cnt_q == 32'(WRITE_CYCLES - 1)) begin
            lw_state_q <= fault_log_pkg::LW_IDLE;
            valid_q <= '0;
            wr_ptr_q <= 4'h0;
            written_q <= 5'h00;
          end
        end
        default: lw_state_q <= fault_log_pkg::LW_IDLE;
      endcase
      for (int c = 0; c < NUM_CH; c++) begin
        if (log_req[c]) begin
          pend_n[c] = 1'b1;
          pend_kind_q[c] <= log_kind_req[c];
        end
      end
      pend_q <= pend_n;
    end
  end

  function automatic logic [7:0] log_byte(input logic [3:0] s, input logic [7:0] i);
    int r;
    r = (int'(i) - int'(fault_log_pkg::BYTE_READINGS)) / 2;
    if (i == 8'h00) begin
      log_byte = 8'h00;
    end else if (i == 8'h01) begin
      log_byte = {4'h0, s};
    end else if (i > fault_log_pkg::LOG_LAST_BYTE || !valid_q[s]) begin
      log_byte = (i > fault_log_pkg::LOG_LAST_BYTE) ? 8'h00 : fault_log_pkg::BLANK_BYTE;
    end else if (i == fault_log_pkg::LOG_LAST_BYTE) begin
      log_byte = fault_log_pkg::LOG_VALID_MARK;
    end else if (i == fault_log_pkg::BYTE_COUNT_LO || i == fault_log_pkg::BYTE_COUNT_LO + 8'h01) begin
      log_byte = i[0] ? count_q[s][15:8] : count_q[s][7:0];
    end else if (i == fault_log_pkg::BYTE_CHAN) begin
      log_byte = chan_q[s];
    end else if (i == fault_log_pkg::BYTE_KIND) begin
      log_byte = kind_q[s];
    end else if (r < NUM_CH) begin
      log_byte = i[0] ? rd_mem_q[s][r][15:8] : rd_mem_q[s][r][7:0];
    end else begin
      log_byte = 8'h00;
    end
  endfunction

  // Command handling and log readout
  fault_log_pkg::rd_state_t rd_state_q;
  logic [3:0] rd_slot_q;
  logic [7:0] rd_byte_q;
  fault_log_pkg::resp_t resp_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_state_q <= fault_log_pkg::RD_IDLE;
      rd_slot_q <= 4'h0;
      rd_byte_q <= 8'h00;
      resp_q <= '0;
      retry_delay_q <= fault_log_pkg::RETRY_DELAY_RST;
    end else begin
      resp_q <= '0;
      case (rd_state_q)
        fault_log_pkg::RD_IDLE: begin
          if (cmd.valid && cmd.write && cmd.code == fault_log_pkg::CMD_FAULT_RETRY) begin
            retry_delay_q <= cmd.data;
          end else if (cmd.valid && !cmd.write && cmd.code == fault_log_pkg::CMD_FAULT_RETRY) begin
            resp_q <= '{valid: 1'b1, last: 1'b1, data: {16'h0000, retry_delay_q}};
          end else if (cmd.valid && !cmd.write && cmd.code == fault_log_pkg::CMD_FAULT_LOG) begin
            if (cmd.block) begin
              rd_state_q <= fault_log_pkg::RD_STREAM;
              resp_q <= '{valid: 1'b1, last: 1'b0, data: {24'h00_0000, log_byte(rd_slot_q, 8'h00)}};
              rd_byte_q <= 8'h01;
            end else begin
              resp_q.valid <= 1'b1;
              resp_q.last <= rd_byte_q >= fault_log_pkg::LOG_LAST_BYTE - 8'h03;
              resp_q.data <= {log_byte(rd_slot_q, rd_byte_q + 8'h03), log_byte(rd_slot_q, rd_byte_q + 8'h02),
                              log_byte(rd_slot_q, rd_byte_q + 8'h01), log_byte(rd_slot_q, rd_byte_q)};
              if (rd_byte_q >= fault_log_pkg::LOG_LAST_BYTE - 8'h03) begin
                rd_byte_q <= 8'h00;
                rd_slot_q <= next_slot(rd_slot_q);
              end else begin
                rd_byte_q <= rd_byte_q + 8'h04;
              end
            end
          end
        end
        fault_log_pkg::RD_STREAM: begin
          resp_q <= '{valid: 1'b1, last: rd_byte_q == fault_log_pkg::LOG_LAST_BYTE,
                      data: {24'h00_0000, log_byte(rd_slot_q, rd_byte_q)}};
          if (rd_byte_q == fault_log_pkg::LOG_LAST_BYTE) begin
            rd_state_q <= fault_log_pkg::RD_IDLE;
            rd_byte_q <= 8'h00;
            rd_slot_q <= next_slot(rd_slot_q);
          end else begin
            rd_byte_q <= rd_byte_q + 8'h01;
          end
        end
        default: rd_state_q <= fault_log_pkg::RD_IDLE;
      endcase
    end
  end

  assign resp = resp_q;
  assign fault_output_n = fout_n_q;
  assign supply_enable_n = psen_n_q;
  assign general_output_n = galarm_n_q;
  assign fault_status = status_q;
  assign status_cml_bit0 = cml_q;
  assign alert_n = alert_n_q;
  assign log_busy = lw_state_q != fault_log_pkg::LW_IDLE;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  ignore_code_a: assert property (fault_hit[1][0] && resp_code(fault_response_config[1], 0) == 2'h0 && !tick_q
    |=> $stable(fmask_q[1]) && $stable(psoff_q[1])) else $error("code 00 changed an output");
  global_assert_a: assert property (fault_hit[0][0] && resp_code(fault_response_config[0], 0) == 2'h2
    && fault_response_config[0][14] && fault_response_config[0][16] |-> ##2 !fault_output_n[0])
    else $error("global retry did not assert fault output");
  local_latch_a: assert property (fault_hit[1][1] && resp_code(fault_response_config[1], 1) == 2'h1
    && !fault_response_config[1][14] |=> psoff_q[1] ##1 supply_enable_n[1]) else $error("local latch left supply on");
  alert_raise_a: assert property (alert_enable && fault_hit[0][0] && !status_q[0][0] |=> !alert_n)
    else $error("alert not raised on new status");
  uv_alarm_a: assert property (fault_response_config[1][10:8] == 3'h2 && $stable(fault_response_config[1][10:8])
    |=> general_output_n[1] == !$past(uv_level[1])) else $error("undervoltage alarm not following condition");
  seq_hold_a: assert property (seq_alarm_q[0] && !clear_faults && !master_off |=> seq_alarm_q[0])
    else $error("sequencing alarm dropped early");
  full_flag_a: assert property ($changed(written_q) && written_q == 5'(NL) |-> cml_q)
    else $error("log full flag not set");
  single_write_a: assert property (lw_state_q == fault_log_pkg::LW_WRITE |=> $stable(lw_slot_q))
    else $error("log slot changed during write");
  block_start_a: assert property (rd_state_q == fault_log_pkg::RD_IDLE && cmd.valid && !cmd.write && cmd.block
    && cmd.code == fault_log_pkg::CMD_FAULT_LOG |=> resp.valid && resp.data[7:0] == 8'h00)
    else $error("block read began with a count byte");
endmodule
`default_nettype wire

// ==== supply_model.sv ====
// Purpose: Behavioural power supplies switched by the low-active enables
// Assumes: One rail per channel; rails ramp after a fixed number of cycles
// Notes: OFF_DLY sets both the turn-on and turn-off delay; the retry delay must stay above it
`timescale 1ns/1ps
`default_nettype none
module supply_model #(
  parameter int N = 2,
  parameter int OFF_DLY = 2
) (
  input wire logic core_clk, // Clock
  input wire logic [N-1:0] supply_enable_n, // Enables from the block
  output logic [N-1:0] rail_up // Rail in regulation
);
  logic [N-1:0] pipe_q [0:OFF_DLY-1];
  always_ff @(posedge core_clk) begin
    pipe_q[0] <= ~supply_enable_n;
    for (int i = 1; i < OFF_DLY; i++) begin
      pipe_q[i] <= pipe_q[i-1];
    end
  end
  assign rail_up = pipe_q[OFF_DLY-1];
endmodule
`default_nettype wire

// ==== test_fault_response_logger.sv ====
// Purpose: Self-checking bench for fault responses, alarms and logs
// Assumes: Short tick and write counts; two channels
// Notes: Inputs change at rising or falling edges; outputs are sampled at falling edges
`timescale 1ns/1ps
`default_nettype none
module test_fault_response_logger;
  logic core_clk = 0, reset = 1, alert_enable = 1, clear_faults = 0, operation_off = 0;
  logic log_overwrite_select = 0, log_clear_bit = 0, log_busy, status_cml_bit0, alert_n;
  logic [1:0][31:0] cfg = '0;
  logic [1:0][5:0] sel = {6'h20, 6'h10};
  logic [1:0][3:0] hits = '0;
  logic [1:0][3:0] fault_status;
  logic [1:0][15:0] reading = {16'h5678, 16'h1234};
  logic [1:0] uv_level = '0, ov_level = '0, uv_warn = '0, ov_warn = '0, other_fault = '0;
  logic [1:0] supply_request = 2'h3, measure_enable = 2'h1, supply_enable_n, general_output_n, rail_up;
  logic [3:0] power_control_input_n = 4'hf;
  logic [2:0] fault_output_n;
  fault_log_pkg::cmd_t cmd = '0;
  fault_log_pkg::resp_t resp;
  logic [7:0] lb [0:259];
  int n_errors = 0, cmp_count = 0, nb, i;
  always #12.5 core_clk = ~core_clk;
  fault_response_logger #(.NUM_CH(2), .TICK_CYCLES(4), .WRITE_CYCLES(5)) dut (.core_clk(core_clk),
    .reset(reset), .fault_response_config(cfg), .channel_config(sel), .fault_hit(hits),
    .uv_level(uv_level), .ov_level(ov_level), .uv_warn(uv_warn), .ov_warn(ov_warn),
    .other_fault(other_fault), .supply_request(supply_request), .measure_enable(measure_enable),
    .reading(reading), .alert_enable(alert_enable), .clear_faults(clear_faults),
    .operation_off(operation_off), .power_control_input_n(power_control_input_n),
    .log_overwrite_select(log_overwrite_select), .log_clear_bit(log_clear_bit), .cmd(cmd),
    .resp(resp), .fault_output_n(fault_output_n), .supply_enable_n(supply_enable_n),
    .general_output_n(general_output_n), .fault_status(fault_status),
    .status_cml_bit0(status_cml_bit0), .alert_n(alert_n), .log_busy(log_busy));
  supply_model #(.N(2), .OFF_DLY(2)) rails (.core_clk(core_clk), .supply_enable_n(supply_enable_n),
    .rail_up(rail_up));
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic hit(input int c, input int k);
    cyc(1);
    hits[c][k] <= 1'b1;
    cyc(1);
    hits <= '0;
  endtask
  task automatic wait_idle;
    cyc(3);
    for (i = 0; i < 30 && log_busy !== 1'b0; i++) @(negedge core_clk);
    if (i == 30) begin
      n_errors++;
      print_verdict;
    end
  endtask
  task automatic rd_log(input logic blk);
    int k, j;
    nb = 0;
    @(negedge core_clk);
    for (k = 0; k < 400 && !(resp.valid === 1'b1 && resp.last === 1'b1); k++) begin
      // Four-byte reads need one command per packet; a block read needs one in all
      if (!blk || k == 0) begin
        cyc(1);
        cmd <= '{1'b1, 1'b0, blk, fault_log_pkg::CMD_FAULT_LOG, 16'h0000};
        cyc(1);
        cmd <= '0;
      end
      @(negedge core_clk);
      if (resp.valid === 1'b1) begin
        for (j = 0; j < (blk ? 1 : 4); j++) begin
          lb[nb] = resp.data[8*j+:8];
          nb++;
        end
      end
    end
    if (k == 400) begin
      n_errors++;
      print_verdict;
    end
  endtask
  task automatic t_global;
    cyc(1);
    cmd <= '{1'b1, 1'b1, 1'b0, fault_log_pkg::CMD_FAULT_RETRY, 16'h0002};
    cfg[0] <= 32'h0005_4102;
    other_fault <= 2'h1;
    cyc(1);
    cmd <= '0;
    hit(0, 0);
    cyc(1);
    @(negedge core_clk);
    chk(fault_output_n, 3'h2);
    chk(fault_status[0][0], 1'b1);
    chk(alert_n, 1'b0);
    cyc(40);
    @(negedge core_clk);
    chk(fault_output_n, 3'h2);
    other_fault <= '0;
    for (i = 0; i < 20 && fault_output_n !== 3'h7; i++) @(negedge core_clk);
    chk(fault_output_n, 3'h7);
    cfg[0] <= 32'h0005_4108;
    other_fault <= 2'h1;
    hit(0, 1);
    cyc(2);
    for (i = 0; i < 20 && fault_output_n !== 3'h7; i++) @(negedge core_clk);
    chk(fault_output_n, 3'h7);
    other_fault <= '0;
    $display("global retry done");
  endtask
  task automatic t_alarm;
    cfg[1] <= 32'h0000_0204;
    uv_level <= 2'h2;
    cyc(3);
    @(negedge core_clk);
    chk(general_output_n[1], 1'b0);
    uv_level <= '0;
    cyc(3);
    @(negedge core_clk);
    chk(general_output_n[1], 1'b1);
    hit(0, 2);
    cyc(25);
    @(negedge core_clk);
    chk(general_output_n[0], 1'b0);
    clear_faults <= 1'b1;
    cyc(1);
    clear_faults <= 1'b0;
    cyc(3);
    @(negedge core_clk);
    chk(general_output_n[0], 1'b1);
    hit(0, 2);
    cyc(3);
    power_control_input_n <= 4'he;
    cyc(1);
    power_control_input_n <= 4'hf;
    cyc(3);
    @(negedge core_clk);
    chk(general_output_n[0], 1'b1);
    $display("alarms done");
  endtask
  task automatic t_local;
    hit(1, 1);
    cyc(30);
    @(negedge core_clk);
    chk(supply_enable_n, 2'h2);
    chk(rail_up, 2'h1);
    chk(fault_output_n, 3'h7);
    $display("local latch done");
  endtask
  task automatic t_codes;
    cfg[1] <= 32'h0000_80c4;
    hit(1, 0);
    cyc(3);
    @(negedge core_clk);
    chk({fault_status[1][0], log_busy, supply_enable_n}, 4'ha);
    hit(1, 3);
    cyc(2);
    @(negedge core_clk);
    chk({fault_status[1][3], log_busy, fault_output_n}, 5'h1f);
    wait_idle;
    $display("response codes done");
  endtask
  task automatic t_read;
    rd_log(1'b1);
    chk(nb, 255);
    chk({lb[254], lb[4], lb[6], lb[7], lb[8], lb[9]}, 48'hdd01_3412_0000);
    rd_log(1'b0);
    chk(nb, 256);
    chk({lb[2], lb[128], lb[253]}, 24'hffff_ff);
    chk(lb[1], 8'h01);
    $display("log readout done");
  endtask
  task automatic t_fill;
    for (int n = 0; n < 14; n++) begin
      if (n == 13) chk(status_cml_bit0, 1'b0);
      hit(1, 3);
      wait_idle;
    end
    @(negedge core_clk);
    chk(status_cml_bit0, 1'b1);
    hit(1, 3);
    cyc(3);
    @(negedge core_clk);
    chk(log_busy, 1'b0);
    $display("log fill done");
  endtask
  initial begin
    cyc(4);
    reset <= 1'b0;
    @(negedge core_clk);
    chk({fault_output_n, supply_enable_n, alert_n, log_busy}, 7'h7e);
    t_global;
    t_alarm;
    t_local;
    t_codes;
    t_read;
    t_fill;
    print_verdict;
  end
  initial begin
    #2500000;
    n_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
